// ---- shared/tsl_regs.vh ----
// Register map, field layout, reset values and link timing of the
// status/limiter/volume register bank. Definitions only.
`ifndef TSL_REGS_VH
`define TSL_REGS_VH

// Register indices; byte address on the bus is four times the index
`define TSL_IDX_STATUS_SLOT   6'h13
`define TSL_IDX_OC_ICC        6'h15
`define TSL_IDX_AUDIO_SLOT    6'h16
`define TSL_IDX_LIM_ATTEN     6'h17
`define TSL_IDX_VOLUME        6'h1a
`define TSL_IDX_LIM_CFG_A     6'h1b
`define TSL_IDX_LIM_CFG_B     6'h1c

// Reset values
`define TSL_RST_STATUS_SLOT   8'h08
`define TSL_RST_OC_ICC        8'h00
`define TSL_RST_AUDIO_SLOT    8'h12
`define TSL_RST_LIM_ATTEN     8'h80
`define TSL_RST_VOLUME        8'h00
`define TSL_RST_LIM_CFG_A     8'h62
`define TSL_RST_LIM_CFG_B     8'h36

// Writable bit masks; cleared bits are reserved and read their reset value
`define TSL_WM_STATUS_SLOT    8'hff
`define TSL_WM_OC_ICC         8'hfc
`define TSL_WM_AUDIO_SLOT     8'hff
`define TSL_WM_LIM_ATTEN      8'hf0
`define TSL_WM_VOLUME         8'hff
`define TSL_WM_LIM_CFG_A      8'hbf
`define TSL_WM_LIM_CFG_B      8'h7f

// Field positions
`define TSL_F_OVP_SEL         7
`define TSL_F_STATUS_TX       6
`define TSL_F_SLOT            5:0
`define TSL_F_LOW_SIDE_OVERCURRENT_TRIM           7:5
`define TSL_F_ICC_FN          4:2
`define TSL_F_AUDIO_LEN       7
`define TSL_F_AUDIO_TX        6
`define TSL_F_MAX_ATTEN       7:4
`define TSL_F_LIM_SRC         7
`define TSL_F_LIM_HR          5
`define TSL_F_LIM_ATK         4:1
`define TSL_F_LIMITER_ENABLE          0
`define TSL_F_LIM_RLS         6:3
`define TSL_F_LIM_HOLD        2:0

// Encodings
`define TSL_ICC_GAIN_SLOT     3'h0
`define TSL_ICC_OFF           3'h2
`define TSL_ICC_GPI           3'h3
`define TSL_ICC_GPO           3'h4
`define TSL_ATTEN_RSVD        4'hf
`define TSL_VOL_MAX           8'hc8
`define TSL_HOLD_RSVD         3'h0

// Link framing: one slot index spans 8 bit clocks, given here as its log2
`define TSL_SLOT_BITS_LOG2    3
`define TSL_STATUS_BITS       10'h008
`define TSL_AUDIO_BITS_SHORT  10'h010
`define TSL_AUDIO_BITS_LONG   10'h018
`define TSL_AUDIO_MSB         23

`endif

// ---- hdl/tsl_regs_bank.v ----
// Status-slot, trim, limiter and volume register bank with TDM transmitter.
// Assumes a classic Wishbone master on clk_i, and a TDM bit clock and frame
// sync from the bus host, both asynchronous to clk_i and much slower.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`include "tsl_regs.vh"

module tsl_regs_bank (
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // TDM link, asynchronous
  input  wire        tdm_bclk_i,
  input  wire        tdm_fsync_i,
  output reg         tdm_sdout_o,
  output reg         tdm_sdout_oe_o,
  // Device state, on clk_i
  input  wire        undervoltage_lockout_i,
  input  wire        overcurrent_i,
  input  wire        over_temp_flag_i,
  input  wire        power_threshold_one_i,
  input  wire        power_threshold_two_i,
  input  wire        brownout_prevention_i,
  input  wire        distortion_limit_i,
  input  wire        noise_gate_i,
  input  wire        high_supply_rail_i,
  input  wire        powered_up_i,
  input  wire [23:0] audio_sample_i,
  // Decoded controls to the signal path
  output reg  [2:0]  low_side_overcurrent_trim_o,
  output reg         trim_raise_o,
  output reg  [5:0]  trim_percent_o,
  output reg  [2:0]  interchip_pin_function_o,
  output reg         interchip_gain_slot_o,
  output reg         interchip_buffers_off_o,
  output reg         interchip_gpi_o,
  output reg         interchip_gpo_o,
  output reg         interchip_reserved_o,
  output reg  [4:0]  limiter_max_attenuation_db_o,
  output reg  [7:0]  volume_attenuation_level_o,
  output reg         volume_mute_o,
  output reg         limiter_source_select_o,
  output reg         limiter_enable_o,
  output reg         limiter_headroom_enable_o,
  output reg  [3:0]  limiter_attack_rate_o,
  output reg  [3:0]  limiter_release_rate_o,
  output reg  [9:0]  limiter_hold_time_ms_o
);

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  reg  [7:0] status_slot_ctrl_q;
  reg  [7:0] overcurrent_interchip_pin_function_q;
  reg  [7:0] audio_out_slot_ctrl_q;
  reg  [7:0] limiter_max_atten_q;
  reg  [7:0] volume_level_q;
  reg  [7:0] limiter_cfg_a_q;
  reg  [7:0] limiter_cfg_b_q;

  wire [5:0] idx_w   = wb_adr_i[7:2];
  wire       req_w   = wb_cyc_i & wb_stb_i;
  // Write lands on the edge where the master sees ack, lane 0 only
  wire       wr_w    = req_w & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire [7:0] wd_w    = wb_dat_i[7:0];

  // Masked merge keeps reserved bits at their reset value
  function [7:0] merge;
    input [7:0] rst_val;
    input [7:0] mask;
    input [7:0] data;
    begin
      merge = (data & mask) | (rst_val & ~mask);
    end
  endfunction

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  reg [7:0] rd_d;

  always @* begin
    if (idx_w == `TSL_IDX_STATUS_SLOT) begin
      rd_d = status_slot_ctrl_q;
    end else if (idx_w == `TSL_IDX_OC_ICC) begin
      rd_d = overcurrent_interchip_pin_function_q;
    end else if (idx_w == `TSL_IDX_AUDIO_SLOT) begin
      rd_d = audio_out_slot_ctrl_q;
    end else if (idx_w == `TSL_IDX_LIM_ATTEN) begin
      rd_d = limiter_max_atten_q;
    end else if (idx_w == `TSL_IDX_VOLUME) begin
      rd_d = volume_level_q;
    end else if (idx_w == `TSL_IDX_LIM_CFG_A) begin
      rd_d = limiter_cfg_a_q;
    end else if (idx_w == `TSL_IDX_LIM_CFG_B) begin
      rd_d = limiter_cfg_b_q;
    end else begin
      rd_d = 8'h00;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      // Unmapped indices still ack, reading zero
      wb_ack_o <= req_w & ~wb_ack_o;
      if (req_w & ~wb_ack_o) begin
        wb_dat_o <= {24'h00_0000, rd_d};
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      status_slot_ctrl_q    <= `TSL_RST_STATUS_SLOT;
      overcurrent_interchip_pin_function_q <= `TSL_RST_OC_ICC;
      audio_out_slot_ctrl_q <= `TSL_RST_AUDIO_SLOT;
      limiter_max_atten_q   <= `TSL_RST_LIM_ATTEN;
      volume_level_q        <= `TSL_RST_VOLUME;
      limiter_cfg_a_q       <= `TSL_RST_LIM_CFG_A;
      limiter_cfg_b_q       <= `TSL_RST_LIM_CFG_B;
    end else if (wr_w) begin
      if (idx_w == `TSL_IDX_STATUS_SLOT) begin
        status_slot_ctrl_q <= merge(`TSL_RST_STATUS_SLOT, `TSL_WM_STATUS_SLOT, wd_w);
      end else if (idx_w == `TSL_IDX_OC_ICC) begin
        overcurrent_interchip_pin_function_q <= merge(`TSL_RST_OC_ICC, `TSL_WM_OC_ICC, wd_w);
      end else if (idx_w == `TSL_IDX_AUDIO_SLOT) begin
        audio_out_slot_ctrl_q <= merge(`TSL_RST_AUDIO_SLOT, `TSL_WM_AUDIO_SLOT, wd_w);
      end else if (idx_w == `TSL_IDX_LIM_ATTEN) begin
        limiter_max_atten_q <= merge(`TSL_RST_LIM_ATTEN, `TSL_WM_LIM_ATTEN, wd_w);
      end else if (idx_w == `TSL_IDX_VOLUME) begin
        volume_level_q <= merge(`TSL_RST_VOLUME, `TSL_WM_VOLUME, wd_w);
      end else if (idx_w == `TSL_IDX_LIM_CFG_A) begin
        limiter_cfg_a_q <= merge(`TSL_RST_LIM_CFG_A, `TSL_WM_LIM_CFG_A, wd_w);
      end else if (idx_w == `TSL_IDX_LIM_CFG_B) begin
        limiter_cfg_b_q <= merge(`TSL_RST_LIM_CFG_B, `TSL_WM_LIM_CFG_B, wd_w);
      end
    end
  end

  // ------------------------------------------------------------
  // Decoded controls
  // ------------------------------------------------------------
  wire [2:0] low_side_overcurrent_trim_w  = overcurrent_interchip_pin_function_q[`TSL_F_LOW_SIDE_OVERCURRENT_TRIM];
  wire [2:0] icc_w    = overcurrent_interchip_pin_function_q[`TSL_F_ICC_FN];
  wire [3:0] atten_w  = limiter_max_atten_q[`TSL_F_MAX_ATTEN];
  wire [2:0] hold_w   = limiter_cfg_b_q[`TSL_F_LIM_HOLD];
  reg  [5:0] trim_pct_d;
  reg  [9:0] hold_ms_d;

  always @* begin
    case (low_side_overcurrent_trim_w)
      3'h1:    trim_pct_d = 6'd10;
      3'h2:    trim_pct_d = 6'd20;
      3'h3:    trim_pct_d = 6'd30;
      3'h4:    trim_pct_d = 6'd40;
      3'h5:    trim_pct_d = 6'd30;
      3'h6:    trim_pct_d = 6'd20;
      3'h7:    trim_pct_d = 6'd10;
      default: trim_pct_d = 6'd0;
    endcase
    case (hold_w)
      3'h1:    hold_ms_d = 10'd10;
      3'h2:    hold_ms_d = 10'd25;
      3'h3:    hold_ms_d = 10'd50;
      3'h4:    hold_ms_d = 10'd100;
      3'h5:    hold_ms_d = 10'd250;
      3'h6:    hold_ms_d = 10'd500;
      3'h7:    hold_ms_d = 10'd1000;
      default: hold_ms_d = 10'd0;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      low_side_overcurrent_trim_o  <= 3'h0;
      trim_raise_o                 <= 1'b0;
      trim_percent_o               <= 6'h00;
      interchip_pin_function_o     <= `TSL_ICC_GAIN_SLOT;
      interchip_gain_slot_o        <= 1'b0;
      interchip_buffers_off_o      <= 1'b0;
      interchip_gpi_o              <= 1'b0;
      interchip_gpo_o              <= 1'b0;
      interchip_reserved_o         <= 1'b0;
      limiter_max_attenuation_db_o <= 5'h00;
      volume_attenuation_level_o   <= 8'h00;
      volume_mute_o                <= 1'b0;
      limiter_source_select_o      <= 1'b0;
      limiter_enable_o             <= 1'b0;
      limiter_headroom_enable_o    <= 1'b0;
      limiter_attack_rate_o        <= 4'h0;
      limiter_release_rate_o       <= 4'h0;
      limiter_hold_time_ms_o       <= 10'h000;
    end else begin
      low_side_overcurrent_trim_o  <= low_side_overcurrent_trim_w;
      trim_raise_o                 <= (low_side_overcurrent_trim_w != 3'h0) & ~low_side_overcurrent_trim_w[2];
      trim_percent_o               <= trim_pct_d;
      interchip_pin_function_o     <= icc_w;
      interchip_gain_slot_o        <= (icc_w == `TSL_ICC_GAIN_SLOT);
      interchip_buffers_off_o      <= (icc_w == `TSL_ICC_OFF);
      interchip_gpi_o              <= (icc_w == `TSL_ICC_GPI);
      interchip_gpo_o              <= (icc_w == `TSL_ICC_GPO);
      interchip_reserved_o         <= (icc_w != `TSL_ICC_GAIN_SLOT) & (icc_w != `TSL_ICC_OFF)
                                      & (icc_w != `TSL_ICC_GPI) & (icc_w != `TSL_ICC_GPO);
      // Reserved code reports zero attenuation rather than 16 dB
      limiter_max_attenuation_db_o <= (atten_w == `TSL_ATTEN_RSVD) ? 5'h00
                                      : {1'b0, atten_w} + 5'h01;
      volume_attenuation_level_o   <= volume_level_q;
      volume_mute_o                <= (volume_level_q > `TSL_VOL_MAX);
      limiter_source_select_o      <= limiter_cfg_a_q[`TSL_F_LIM_SRC];
      limiter_enable_o             <= limiter_cfg_a_q[`TSL_F_LIMITER_ENABLE];
      limiter_headroom_enable_o    <= limiter_cfg_a_q[`TSL_F_LIMITER_ENABLE]
                                      & limiter_cfg_a_q[`TSL_F_LIM_HR];
      limiter_attack_rate_o        <= limiter_cfg_a_q[`TSL_F_LIM_ATK];
      limiter_release_rate_o       <= limiter_cfg_b_q[`TSL_F_LIM_RLS];
      limiter_hold_time_ms_o       <= hold_ms_d;
    end
  end

  // ------------------------------------------------------------
  // Status word
  // ------------------------------------------------------------
  wire       ovp_sel_w = status_slot_ctrl_q[`TSL_F_OVP_SEL];
  wire [7:0] status_w;

  assign status_w[7] = undervoltage_lockout_i;
  assign status_w[6] = ovp_sel_w ? power_threshold_one_i
                                 : overcurrent_i;
  assign status_w[5] = ovp_sel_w ? (power_threshold_two_i | over_temp_flag_i)
                                 : over_temp_flag_i;
  assign status_w[4] = brownout_prevention_i;
  assign status_w[3] = distortion_limit_i;
  assign status_w[2] = noise_gate_i;
  assign status_w[1] = high_supply_rail_i;
  assign status_w[0] = powered_up_i;

  // ------------------------------------------------------------
  // TDM link: bit clock and frame sync sampled by clk_i
  // ------------------------------------------------------------
  reg        bclk_s1_q, bclk_s2_q, bclk_s3_q;
  reg        fs_s1_q, fs_s2_q, fs_prev_q;
  reg  [9:0] bit_cnt_q;
  reg        in_frame_q;
  reg  [7:0] status_shift_q;
  reg  [23:0] audio_shift_q;

  // Third bclk stage is the edge reference; the first stage feeds only the second
  wire bclk_rise_w = bclk_s2_q & ~bclk_s3_q;
  wire bclk_fall_w = ~bclk_s2_q & bclk_s3_q;
  wire frame_w     = fs_s2_q & ~fs_prev_q;

  wire [9:0] st_base_w = {1'b0, status_slot_ctrl_q[`TSL_F_SLOT], 3'h0};
  wire [9:0] au_base_w = {1'b0, audio_out_slot_ctrl_q[`TSL_F_SLOT], 3'h0};
  wire [9:0] au_len_w  = audio_out_slot_ctrl_q[`TSL_F_AUDIO_LEN]
                         ? `TSL_AUDIO_BITS_LONG : `TSL_AUDIO_BITS_SHORT;
  wire [9:0] st_off_w  = bit_cnt_q - st_base_w;
  wire [9:0] au_off_w  = bit_cnt_q - au_base_w;
  wire       st_hit_w  = status_slot_ctrl_q[`TSL_F_STATUS_TX]
                         & (bit_cnt_q >= st_base_w) & (st_off_w < `TSL_STATUS_BITS);
  wire       au_hit_w  = audio_out_slot_ctrl_q[`TSL_F_AUDIO_TX]
                         & (bit_cnt_q >= au_base_w) & (au_off_w < au_len_w);

  always @(posedge clk_i) begin
    if (rst_i) begin
      bclk_s1_q <= 1'b0;
      bclk_s2_q <= 1'b0;
      bclk_s3_q <= 1'b0;
      fs_s1_q   <= 1'b0;
      fs_s2_q   <= 1'b0;
      fs_prev_q <= 1'b0;
    end else begin
      bclk_s1_q <= tdm_bclk_i;
      bclk_s2_q <= bclk_s1_q;
      bclk_s3_q <= bclk_s2_q;
      fs_s1_q   <= tdm_fsync_i;
      fs_s2_q   <= fs_s1_q;
      if (bclk_rise_w) begin
        fs_prev_q <= fs_s2_q;
      end
    end
  end

  // Frame counter advances on bclk rise; data launches on bclk fall
  always @(posedge clk_i) begin
    if (rst_i) begin
      bit_cnt_q      <= 10'h000;
      in_frame_q     <= 1'b0;
      status_shift_q <= 8'h00;
      audio_shift_q  <= 24'h00_0000;
      tdm_sdout_o    <= 1'b0;
      tdm_sdout_oe_o <= 1'b0;
    end else begin
      if (bclk_rise_w) begin
        if (frame_w) begin
          bit_cnt_q  <= 10'h000;
          in_frame_q <= 1'b1;
        end else if (in_frame_q) begin
          // Counter parks at the top; a missing sync ends transmission
          if (bit_cnt_q == 10'h3ff) begin
            in_frame_q <= 1'b0;
          end else begin
            bit_cnt_q <= bit_cnt_q + 10'h001;
          end
        end
      end
      if (bclk_fall_w) begin
        // Status owns any bit that overlaps the audio slot
        if (in_frame_q & st_hit_w) begin
          if (st_off_w == 10'h000) begin
            tdm_sdout_o    <= status_w[7];
            status_shift_q <= {status_w[6:0], 1'b0};
          end else begin
            tdm_sdout_o    <= status_shift_q[7];
            status_shift_q <= {status_shift_q[6:0], 1'b0};
          end
          tdm_sdout_oe_o <= 1'b1;
        end else if (in_frame_q & au_hit_w) begin
          if (au_off_w == 10'h000) begin
            tdm_sdout_o   <= audio_sample_i[`TSL_AUDIO_MSB];
            audio_shift_q <= {audio_sample_i[22:0], 1'b0};
          end else begin
            tdm_sdout_o   <= audio_shift_q[`TSL_AUDIO_MSB];
            audio_shift_q <= {audio_shift_q[22:0], 1'b0};
          end
          tdm_sdout_oe_o <= 1'b1;
        end else begin
          tdm_sdout_o    <= 1'b0;
          tdm_sdout_oe_o <= 1'b0;
        end
      end
    end
  end

endmodule // tsl_regs_bank

// ---- verif/tsl_regs_bank_properties.sv ----
// Checker of bus handshake and decoded controls of the register bank.
// Assumes it is bound to tsl_regs_bank and sees only its ports.
`timescale 1ns/1ps
module tsl_regs_bank_chk (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire [31:0] wb_dat_o,
  input wire [2:0]  low_side_overcurrent_trim_o,
  input wire        trim_raise_o,
  input wire [5:0]  trim_percent_o,
  input wire [2:0]  interchip_pin_function_o,
  input wire        interchip_gpo_o,
  input wire        interchip_reserved_o,
  input wire [7:0]  volume_attenuation_level_o,
  input wire        volume_mute_o,
  input wire        limiter_enable_o,
  input wire        limiter_headroom_enable_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire [6:0] code_x10 = {4'h0, low_side_overcurrent_trim_o} * 7'd10;

  ack_follows_req_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack missing after request");
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_has_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  rd_upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  vol_mute_a: assert property (volume_mute_o == (volume_attenuation_level_o > 8'hc8))
    else $error("mute decode wrong");
  hr_needs_en_a: assert property (limiter_headroom_enable_o |-> limiter_enable_o)
    else $error("headroom without limiter enable");
  trim_pct_a: assert property (trim_percent_o == (low_side_overcurrent_trim_o[2] ?
    7'd80 - code_x10 : code_x10) && trim_raise_o == (low_side_overcurrent_trim_o inside {1, 2, 3}))
    else $error("trim decode wrong");
  icc_decode_a: assert property ($rose(interchip_gpo_o) |-> interchip_pin_function_o == 3'h4
    && !interchip_reserved_o) else $error("pin function decode wrong");
endmodule // tsl_regs_bank_chk

bind tsl_regs_bank tsl_regs_bank_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .low_side_overcurrent_trim_o(low_side_overcurrent_trim_o), .trim_raise_o(trim_raise_o),
  .trim_percent_o(trim_percent_o), .interchip_pin_function_o(interchip_pin_function_o),
  .interchip_gpo_o(interchip_gpo_o), .interchip_reserved_o(interchip_reserved_o),
  .volume_attenuation_level_o(volume_attenuation_level_o), .volume_mute_o(volume_mute_o),
  .limiter_enable_o(limiter_enable_o), .limiter_headroom_enable_o(limiter_headroom_enable_o));

// ---- verif/tsl_tdm_host_model.sv ----
// Behavioural TDM bus host: makes bit clock and frame sync, captures serial out.
// Assumes the testbench calls run_frame; bit clock stands low between frames.
`timescale 1ns/1ps
module tsl_tdm_host_model (
  input  wire logic sdout_i,
  input  wire logic oe_i,
  output logic      bclk_o,
  output logic      fsync_o
);
  logic [199:0] bits_q;
  logic [199:0] en_q;
  logic         last_q;
  // Released line shows the inverse of its last driven value
  wire line = oe_i ? sdout_i : ~last_q;
  initial begin
    bclk_o = 1'b0;
    fsync_o = 1'b0;
    last_q = 1'b0;
  end
  // Sample at the fall that ends each bit, the widest margin after launch
  task automatic run_frame;
    int i;
    bits_q = '0;
    en_q = '0;
    fsync_o = 1'b1;
    #32;
    for (i = 0; i <= 200; i++) begin
      bclk_o = 1'b1;
      #32;
      bclk_o = 1'b0;
      fsync_o = 1'b0;
      if (i > 0) begin
        bits_q[i-1] = line;
        en_q[i-1] = oe_i;
        if (oe_i) last_q = sdout_i;
      end
      #32;
    end
    #200;
  endtask
endmodule // tsl_tdm_host_model

// ---- verif/tsl_regs_bank_tb.sv ----
// Self-checking bench of the register bank: bus access, decodes, TDM slots.
// Assumes the checker is bound by its own file and the host model is present.
`timescale 1ns/1ps
module tsl_regs_bank_tb;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, th1, th2;
  logic [7:0] wb_adr, st;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat;
  wire [31:0] wb_rdat;
  wire wb_ack, bclk, fsync, sdout, oe, raise, mute, src, en, hr;
  wire [5:0] pct;
  wire [4:0] atten, interchip_link;
  wire [9:0] hold;
  wire [2:0] trim, icc_fn;
  wire [7:0] vol;
  wire [3:0] atk, rls;
  int n_mismatch, check_count, cycles;
  localparam logic [5:0] IDX [7] = '{6'h13, 6'h15, 6'h16, 6'h17, 6'h1a, 6'h1b, 6'h1c};
  localparam logic [7:0] RST [7] = '{8'h08, 8'h00, 8'h12, 8'h80, 8'h00, 8'h62, 8'h36};
  localparam logic [7:0] WM [7] = '{8'hff, 8'hfc, 8'hff, 8'hf0, 8'hff, 8'hbf, 8'h7f};
  localparam logic [9:0] HOLD [8] = '{0, 10, 25, 50, 100, 250, 500, 1000};
  localparam logic [5:0] PCT [8] = '{0, 10, 20, 30, 40, 30, 20, 10};
  localparam logic [4:0] INTERCHIP_LINK [8] = '{5'h10, 5'h01, 5'h08, 5'h04, 5'h02, 5'h01, 5'h01, 5'h01};
  localparam logic [23:0] SMP = 24'hc3a51e;

  tsl_regs_bank u_tsl_regs_bank (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .tdm_bclk_i(bclk),
    .tdm_fsync_i(fsync), .tdm_sdout_o(sdout), .tdm_sdout_oe_o(oe),
    .undervoltage_lockout_i(st[7]), .overcurrent_i(st[6]), .over_temp_flag_i(st[5]),
    .power_threshold_one_i(th1), .power_threshold_two_i(th2), .brownout_prevention_i(st[4]),
    .distortion_limit_i(st[3]), .noise_gate_i(st[2]), .high_supply_rail_i(st[1]),
    .powered_up_i(st[0]), .audio_sample_i(SMP), .low_side_overcurrent_trim_o(trim),
    .trim_raise_o(raise), .trim_percent_o(pct), .interchip_pin_function_o(icc_fn),
    .interchip_gain_slot_o(interchip_link[4]), .interchip_buffers_off_o(interchip_link[3]), .interchip_gpi_o(interchip_link[2]),
    .interchip_gpo_o(interchip_link[1]), .interchip_reserved_o(interchip_link[0]),
    .limiter_max_attenuation_db_o(atten), .volume_attenuation_level_o(vol),
    .volume_mute_o(mute),
    .limiter_source_select_o(src), .limiter_enable_o(en), .limiter_headroom_enable_o(hr),
    .limiter_attack_rate_o(atk), .limiter_release_rate_o(rls), .limiter_hold_time_ms_o(hold));
  tsl_tdm_host_model u_tsl_tdm_host_model (.sdout_i(sdout), .oe_i(oe), .bclk_o(bclk),
    .fsync_o(fsync));

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end

  task automatic check(input [31:0] got, input [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic single cycle; caller sits just after a rising edge
  task automatic wb_xfer(input bit wr, input [5:0] idx, input [7:0] d, input [3:0] sel,
                         output [31:0] q);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= wr;
    wb_adr <= {idx, 2'h0};
    wb_sel <= sel;
    wb_wdat <= {24'h0, d};
    @(posedge clk_i);
    while (wb_ack !== 1'b1) @(posedge clk_i);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input [5:0] idx, input [7:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, idx, d, 4'h1, q);
    repeat (2) @(posedge clk_i);
  endtask
  task automatic rd_chk(input [5:0] idx, input [7:0] exp);
    logic [31:0] q;
    wb_xfer(1'b0, idx, 8'h00, 4'h1, q);
    check(q, {24'h0, exp});
  endtask
  task automatic tdm_check(input int first, input int len, input [23:0] exp);
    logic [23:0] got;
    int i, win, tot;
    got = '0;
    win = 0;
    tot = 0;
    for (i = 0; i < 200; i++) tot += u_tsl_tdm_host_model.en_q[i];
    for (i = 0; i < len; i++) begin
      got[23-i] = u_tsl_tdm_host_model.bits_q[first+i];
      win += u_tsl_tdm_host_model.en_q[first+i];
    end
    check(got, exp);
    check(win, len);
    check(tot, len);
  endtask

  task automatic test_reset;
    int i;
    for (i = 0; i < 7; i++) rd_chk(IDX[i], RST[i]);
    rd_chk(6'h14, 8'h00);
    check(hold, 10'd500);
    check(atten, 5'd9);
    check({src, en, hr}, 3'b000);
  endtask
  task automatic test_reserved;
    int i;
    logic [31:0] q;
    for (i = 0; i < 7; i++) begin
      wr(IDX[i], 8'hff);
      rd_chk(IDX[i], WM[i] | (RST[i] & ~WM[i]));
      wr(IDX[i], 8'h00);
      wb_xfer(1'b1, IDX[i], 8'h5a, 4'he, q);
      rd_chk(IDX[i], RST[i] & ~WM[i]);
      wr(IDX[i], RST[i]);
    end
    wr(6'h14, 8'hff);
    rd_chk(6'h14, 8'h00);
  endtask
  task automatic test_decode;
    int c;
    for (c = 0; c < 8; c++) begin
      wr(6'h1c, {1'b0, 4'h9, c[2:0]});
      check({rls, hold}, {4'h9, HOLD[c]});
      wr(6'h15, {c[2:0], c[2:0], 2'h0});
      check({raise, pct}, {c >= 1 && c <= 3, PCT[c]});
      check(interchip_link, INTERCHIP_LINK[c]);
      check({trim, icc_fn}, {c[2:0], c[2:0]});
    end
    wr(6'h17, 8'he0);
    check(atten, 5'd15);
    wr(6'h17, 8'hf0);
    check(atten, 5'd0);
    wr(6'h1a, 8'hc8);
    check(mute, 1'b0);
    check(vol, 8'hc8);
    wr(6'h1a, 8'hc9);
    check(mute, 1'b1);
    wr(6'h1b, 8'h80);
    check({src, en, hr}, 3'b100);
    wr(6'h1b, 8'h21);
    check({src, en, hr}, 3'b011);
    wr(6'h1b, 8'h1b);
    check({src, en, hr, atk}, {3'b010, 4'hd});
  endtask
  task automatic status_frame(input [7:0] ctl, input [7:0] s, input int first,
                              input int len, input [7:0] exp);
    st <= s;
    wr(6'h13, ctl);
    u_tsl_tdm_host_model.run_frame;
    tdm_check(first, len, {exp, 16'h0});
  endtask
  task automatic test_tdm;
    status_frame(8'h48, 8'hb5, 64, 8, 8'hb5);
    status_frame(8'h43, 8'h4a, 24, 8, 8'h4a);
    th2 <= 1'b1;
    status_frame(8'hc3, 8'h41, 24, 8, 8'h21);
    {th1, th2} <= 2'b10;
    status_frame(8'hc3, 8'h20, 24, 8, 8'h60);
    status_frame(8'h88, 8'hff, 0, 0, 8'h00);
    wr(6'h16, 8'hc2);
    u_tsl_tdm_host_model.run_frame;
    tdm_check(16, 24, SMP);
    wr(6'h16, 8'h42);
    u_tsl_tdm_host_model.run_frame;
    tdm_check(16, 16, {SMP[23:8], 8'h00});
  endtask

  task tally_and_finish;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    {wb_cyc, wb_stb, wb_we, th1, th2} = '0;
    wb_adr = '0;
    wb_sel = '0;
    wb_wdat = '0;
    st = '0;
    n_mismatch = 0;
    check_count = 0;
    cycles = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset;
    test_reserved;
    test_decode;
    test_tdm;
    tally_and_finish;
  end
endmodule // tsl_regs_bank_tb
